// ==== tws_pkg.sv ====
// Shared constants and types of the two-wire slave front end
package tws_pkg;
  // Timing of the input spike filter
  localparam int SPIKE_NS = 50;
  localparam int CLK_NS = 40;
  localparam logic [1:0] SPIKE_CYC = 2'((SPIKE_NS + CLK_NS - 1) / CLK_NS);
  // Bit counter landmarks within one byte slot (counts SCL rises)
  localparam logic [3:0] CNT_FIRST = 4'h0;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  // Slave address byte layout
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int PAGE_MSB = 2;
  localparam int PAGE_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int MSB = 7;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h5;

  typedef enum logic [1:0] {
    TWS_ST_IDLE,
    TWS_ST_ADDR,
    TWS_ST_WADDR,
    TWS_ST_WDATA
  } tws_state_e;

  // Received byte handed to the memory side
  typedef struct packed {
    logic is_word;
    logic [1:0] page;
    logic [7:0] data;
  } tws_wbyte_s;
endpackage

// ==== tws_buf2.sv ====
// Two-entry buffer with registered outputs for received bytes
`timescale 1ns/1ps
module tws_buf2 (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Filling side
  input wire logic in_valid_i,
  input tws_pkg::tws_wbyte_s in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output tws_pkg::tws_wbyte_s out_data_o,
  input wire logic out_ready_i
);
  tws_pkg::tws_wbyte_s tail_q;
  logic tail_vld_q;
  wire logic pop = out_valid_o & out_ready_i;
  wire logic push = in_valid_i & ~tail_vld_q;
  wire logic head_free = ~out_valid_o | pop;

  assign in_ready_o = ~tail_vld_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      tail_vld_q <= 1'b0;
      tail_q <= '0;
    end else if (head_free) begin
      out_valid_o <= tail_vld_q | push;
      out_data_o <= tail_vld_q ? tail_q : in_data_i;
      tail_vld_q <= tail_vld_q & push;
      tail_q <= in_data_i;
    end else if (push) begin
      tail_vld_q <= 1'b1;
      tail_q <= in_data_i;
    end
  end

  property p_buf_hold;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      out_valid_o & ~out_ready_i |=> out_valid_o & $stable(out_data_o);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("Buffer head changed while stalled");
endmodule // tws_buf2

// ==== tws_slave.sv ====
// Two-wire bus slave front end with spike filter and byte buffer
`timescale 1ns/1ps
module tws_slave (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Received bytes
  output logic wr_valid_o,
  output tws_pkg::tws_wbyte_s wr_byte_o,
  input wire logic wr_ready_i,
  // Read data
  output logic rd_next_o,
  output logic [1:0] rd_page_o,
  input wire logic [7:0] rd_data_i,
  output logic rd_active_o
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [1:0] scl_fc_q;
  logic [1:0] sda_fc_q;
  tws_pkg::tws_state_e state_q;
  logic [3:0] cnt_q;
  logic [7:0] shf_q;
  logic buf_ready;
  tws_pkg::tws_wbyte_s push_byte;

  // Synchronisers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  wire logic scl_s = scl_sync_q[1];
  wire logic sda_s = sda_sync_q[1];

  // Spike filter: a new level must persist for SPIKE_CYC samples
  function automatic logic [1:0] flt_cnt(input logic differ, input logic [1:0] cnt);
    flt_cnt = (differ && cnt != tws_pkg::SPIKE_CYC - 2'h1) ? cnt + 2'h1 : 2'h0;
  endfunction

  wire logic scl_hit = (scl_s != scl_f_q) && (scl_fc_q == tws_pkg::SPIKE_CYC - 2'h1);
  wire logic sda_hit = (sda_s != sda_f_q) && (sda_fc_q == tws_pkg::SPIKE_CYC - 2'h1);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      scl_fc_q <= 2'h0;
      sda_fc_q <= 2'h0;
    end else begin
      scl_fc_q <= flt_cnt(scl_s != scl_f_q, scl_fc_q);
      sda_fc_q <= flt_cnt(sda_s != sda_f_q, sda_fc_q);
      scl_f_q <= scl_hit ? scl_s : scl_f_q;
      sda_f_q <= sda_hit ? sda_s : sda_f_q;
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Bus events
  wire logic scl_rise = scl_f_q & ~scl_p_q;
  wire logic scl_fall = ~scl_f_q & scl_p_q;
  wire logic start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  wire logic stop_ev = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  wire logic active = state_q != tws_pkg::TWS_ST_IDLE;

  // Byte decode
  wire logic addr_hit = shf_q[tws_pkg::TYPE_MSB:tws_pkg::TYPE_LSB] == tws_pkg::DEV_TYPE;
  wire logic rw_rd = shf_q[tws_pkg::RW_BIT];
  wire logic is_addr = state_q == tws_pkg::TWS_ST_ADDR;
  wire logic is_rx_data = (state_q == tws_pkg::TWS_ST_WADDR) || (state_q == tws_pkg::TWS_ST_WDATA);
  wire logic is_rd = (state_q == tws_pkg::TWS_ST_WDATA) && rd_active_o;
  wire logic is_rx = is_addr || (is_rx_data && !rd_active_o);
  wire logic byte_end = scl_fall && cnt_q == tws_pkg::CNT_ACK;
  wire logic slot_end = scl_fall && cnt_q == tws_pkg::CNT_DONE;
  wire logic ack_ok = is_addr ? addr_hit : buf_ready;
  wire logic push = active && byte_end && is_rx_data && !rd_active_o && buf_ready;
  wire logic addr_rd = is_addr && sda_oe_o && rw_rd;
  wire logic mst_ack = is_rd && !sda_f_q;

  assign push_byte.is_word = state_q == tws_pkg::TWS_ST_WADDR;
  assign push_byte.page = rd_page_o;
  assign push_byte.data = shf_q;

  // Protocol engine
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= tws_pkg::TWS_ST_IDLE;
      cnt_q <= tws_pkg::CNT_FIRST;
      shf_q <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      rd_next_o <= 1'b0;
      rd_page_o <= 2'h0;
      rd_active_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      rd_next_o <= 1'b0;
      if (start_ev) begin
        state_q <= tws_pkg::TWS_ST_ADDR;
        rd_active_o <= 1'b0;
        cnt_q <= tws_pkg::CNT_FIRST;
        sda_oe_o <= 1'b0;
      end else if (stop_ev) begin
        state_q <= tws_pkg::TWS_ST_IDLE;
        rd_active_o <= 1'b0;
        cnt_q <= tws_pkg::CNT_FIRST;
        sda_oe_o <= 1'b0;
      end else if (active && scl_rise) begin
        if (cnt_q != tws_pkg::CNT_ACK) begin
          cnt_q <= cnt_q + 4'h1;
          if (is_rx) begin
            shf_q <= {shf_q[6:0], sda_f_q};
          end
        end else begin
          cnt_q <= tws_pkg::CNT_DONE;
          rd_next_o <= addr_rd || mst_ack;
          if (is_rd && sda_f_q) begin
            state_q <= tws_pkg::TWS_ST_IDLE;
            rd_active_o <= 1'b0;
          end
        end
      end else if (active && scl_fall) begin
        if (byte_end) begin
          if (is_rd) begin
            sda_oe_o <= 1'b0;
          end else if (ack_ok) begin
            sda_oe_o <= 1'b1;
            if (is_addr) begin
              rd_page_o <= shf_q[tws_pkg::PAGE_MSB:tws_pkg::PAGE_LSB];
            end
          end else begin
            state_q <= tws_pkg::TWS_ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        end else if (slot_end) begin
          cnt_q <= tws_pkg::CNT_FIRST;
          if (is_rd || (is_addr && rw_rd)) begin
            state_q <= tws_pkg::TWS_ST_WDATA;
            rd_active_o <= 1'b1;
            shf_q <= rd_data_i;
            sda_oe_o <= ~rd_data_i[tws_pkg::MSB];
          end else begin
            state_q <= is_addr ? tws_pkg::TWS_ST_WADDR : tws_pkg::TWS_ST_WDATA;
            sda_oe_o <= 1'b0;
          end
        end else if (is_rd && cnt_q != tws_pkg::CNT_FIRST) begin
          shf_q <= {shf_q[6:0], 1'b0};
          sda_oe_o <= ~shf_q[6];
        end
      end
    end
  end

  tws_buf2 u_buf (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_valid_i(push),
    .in_data_i(push_byte),
    .in_ready_o(buf_ready),
    .out_valid_o(wr_valid_o),
    .out_data_o(wr_byte_o),
    .out_ready_i(wr_ready_i)
  );

  // Checks
  property p_start_abort;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      start_ev |=> state_q == tws_pkg::TWS_ST_ADDR && cnt_q == tws_pkg::CNT_FIRST && !sda_oe_o;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("Start did not restart");

  property p_stop_idle;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      stop_ev && !start_ev |=> state_q == tws_pkg::TWS_ST_IDLE && !sda_oe_o;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not idle");

  property p_open_drain;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      ##1 sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("SDA driven high");

  property p_idle_quiet;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !active && !start_ev |=> !sda_oe_o && !rd_next_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Idle slave drove bus");

  property p_nack_abort;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      scl_rise && is_rd && cnt_q == tws_pkg::CNT_ACK && sda_f_q && !start_ev && !stop_ev
      |=> state_q == tws_pkg::TWS_ST_IDLE && !rd_next_o;
  endproperty
  a_nack_abort: assert property (p_nack_abort) else $error("Missing ack not aborted");

  property p_write_ack;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      byte_end && is_rx_data && !rd_active_o && buf_ready && !start_ev && !stop_ev
      |=> sda_oe_o && wr_valid_o;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("Write byte not acked");

  property p_read_next;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      scl_rise && mst_ack && cnt_q == tws_pkg::CNT_ACK && !start_ev && !stop_ev |=> rd_next_o;
  endproperty
  a_read_next: assert property (p_read_next) else $error("Master ack gave no fetch");

  property p_release_ack;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      byte_end && is_rd && !start_ev && !stop_ev |=> !sda_oe_o;
  endproperty
  a_release_ack: assert property (p_release_ack) else $error("SDA held in master ack");

  property p_spike;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (sda_s != sda_f_q && sda_fc_q == 2'h0) ##1 (sda_s == sda_f_q) |-> $stable(sda_f_q);
  endproperty
  a_spike: assert property (p_spike) else $error("Spike passed filter");
endmodule // tws_slave

// ==== tws_bm.sv ====
// Behavioural two-wire bus master
`timescale 1ns/1ps
module tws_bm (
  // Clock
  input wire logic clk_i,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  initial scl_o = 1'b1;
  initial pull_o = 1'b0;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One clock slot; long low phase covers the slave's answer delay
  task automatic slot(input logic b, output logic r);
    tk(3);
    pull_o = ~b;
    tk(3);
    scl_o = 1'b1;
    tk(1);
    r = sda_i;
    tk(1);
    scl_o = 1'b0;
  endtask
  // Start or stop condition
  task automatic cond(input logic stop);
    tk(3);
    pull_o = stop;
    tk(3);
    scl_o = 1'b1;
    tk(4);
    pull_o = ~stop;
    tk(4);
    if (!stop) scl_o = 1'b0;
  endtask
  // Clock spike of one sample
  task automatic spike();
    tk(1);
    scl_o = 1'b1;
    tk(1);
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
    output logic ar);
    logic r;
    if (scl_o) begin
      tk(2);
      scl_o = 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      slot(tx[i], r);
      rx[i] = r;
    end
    slot(ab, ar);
  endtask
endmodule // tws_bm

// ==== tb.sv ====
// Testbench of the two-wire slave front end
`timescale 1ns/1ps
module tb;
  logic clk_sys_i;
  logic resetn_i;
  logic wr_ready_i;
  logic [7:0] rd_data_i;
  logic scl, pull, sda_o, sda_oe_o, wr_valid_o, rd_next_o, rd_active_o, ack;
  logic [1:0] rd_page_o;
  logic [1:0] rd_idx = 2'h0;
  logic [7:0] rx;
  logic [7:0] rom [4] = '{8'hC3, 8'h96, 8'h0F, 8'hE1};
  tws_pkg::tws_wbyte_s wr_byte_o;
  tws_pkg::tws_wbyte_s got_q[$];
  int fail_count = 0;
  int checks_done = 0;
  wire sda = ~((sda_oe_o & ~sda_o) | pull);
  always #20 clk_sys_i = ~clk_sys_i;
  tws_slave tws_slave_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o),
    .wr_byte_o(wr_byte_o), .wr_ready_i(wr_ready_i), .rd_next_o(rd_next_o),
    .rd_page_o(rd_page_o), .rd_data_i(rd_data_i), .rd_active_o(rd_active_o));
  tws_bm tws_bm_inst (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  task automatic chk_v(input logic [10:0] g, input logic [10:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v({10'h0, g}, {10'h0, e});
  endtask
  task automatic chk_q(input logic [10:0] e);
    if (got_q.size() == 0) chk_v('x, e);
    else chk_v(got_q.pop_front(), e);
  endtask
  task automatic xa(input logic [7:0] tx, input logic ab, input logic ea);
    tws_bm_inst.xfer(tx, ab, rx, ack);
    chk_b(ack, ea);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Stream sink and read byte source
  always @(posedge clk_sys_i) begin
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) got_q.push_back(wr_byte_o);
    if (sda_oe_o === 1'b1) chk_b(sda_o, 1'b0);
    if (rd_next_o === 1'b1) begin
      rd_data_i <= #1 rom[rd_idx];
      rd_idx <= rd_idx + 2'h1;
    end
  end
  task automatic t_write();
    tws_bm_inst.cond(1'b0);
    tws_bm_inst.spike();
    xa(8'h54, 1'b1, 1'b0);
    xa(8'h3C, 1'b1, 1'b0);
    xa(8'hB5, 1'b1, 1'b0);
    xa(8'h69, 1'b1, 1'b0);
    tws_bm_inst.cond(1'b1);
    chk_q({1'b1, 2'b10, 8'h3C});
    chk_q({1'b0, 2'b10, 8'hB5});
    chk_q({1'b0, 2'b10, 8'h69});
    $display("write test done");
  endtask
  task automatic t_reject();
    xa(8'h54, 1'b1, 1'b1);
    tws_bm_inst.cond(1'b0);
    xa(8'h34, 1'b1, 1'b1);
    xa(8'h54, 1'b1, 1'b1);
    tws_bm_inst.cond(1'b1);
    chk_b(got_q.size() == 0, 1'b1);
    $display("reject test done");
  endtask
  task automatic t_read();
    tws_bm_inst.cond(1'b0);
    xa(8'h53, 1'b1, 1'b0);
    chk_v({9'h0, rd_page_o}, 11'h001);
    xa(8'hFF, 1'b0, 1'b0);
    chk_v({3'h0, rx}, {3'h0, rom[0]});
    chk_b(rd_active_o, 1'b1);
    xa(8'hFF, 1'b1, 1'b1);
    chk_v({3'h0, rx}, {3'h0, rom[1]});
    xa(8'hFF, 1'b1, 1'b1);
    chk_v({3'h0, rx}, 11'h0FF);
    chk_b(rd_active_o, 1'b0);
    tws_bm_inst.cond(1'b1);
    $display("read test done");
  endtask
  task automatic t_abort();
    tws_bm_inst.cond(1'b0);
    xa(8'h54, 1'b1, 1'b0);
    repeat (3) tws_bm_inst.slot(1'b0, ack);
    tws_bm_inst.cond(1'b0);
    xa(8'h56, 1'b1, 1'b0);
    xa(8'h11, 1'b1, 1'b0);
    repeat (3) tws_bm_inst.slot(1'b0, ack);
    tws_bm_inst.cond(1'b1);
    xa(8'h11, 1'b1, 1'b1);
    chk_q({1'b1, 2'b11, 8'h11});
    chk_b(got_q.size() == 0, 1'b1);
    $display("abort test done");
  endtask
  task automatic t_full();
    wr_ready_i = 1'b0;
    tws_bm_inst.cond(1'b0);
    xa(8'h54, 1'b1, 1'b0);
    xa(8'h22, 1'b1, 1'b0);
    xa(8'h33, 1'b1, 1'b0);
    xa(8'h44, 1'b1, 1'b1);
    tws_bm_inst.cond(1'b1);
    chk_b(wr_valid_o, 1'b1);
    wr_ready_i = 1'b1;
    for (int i = 0; i < 8 && got_q.size() < 2; i++) @(posedge clk_sys_i);
    #1;
    if (got_q.size() < 2) fail_count++;
    chk_q({1'b1, 2'b10, 8'h22});
    chk_q({1'b0, 2'b10, 8'h33});
    chk_b(wr_valid_o, 1'b0);
    $display("buffer test done");
  endtask
  initial begin
    clk_sys_i = 1'b0;
    resetn_i = 1'b0;
    wr_ready_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    t_write();
    t_reject();
    t_read();
    t_abort();
    t_full();
    summarize();
  end
endmodule // tb
